//--- core/general_purpose_io_bank.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "gpio_bank_consts.svh"

// Overview of operation
// - function-select bit 1 routes the pin to GPIO, 0 to its native function.
// - function-select bits of absent pins read 0 and ignore writes.
// - function-select bits of pins without native function are fixed at 1.
// - resume reset sets muxed pins native; platform reset alone makes core pins GPIO.
// - switching native to GPIO output is glitch free.
// - direction 0 is output, 1 is input; direction resets to 0000ffff.
// - fixed outputs read direction 0, low sixteen fixed inputs read 1, unchangeable.
// - output pins drive the level bit; input pins read back the sampled pin.
// - resume level bits reset on resume reset and on reset-control port write.
// - core level bits reset to default on platform reset.
// - blink on an output toggles the pin each half second.
// - blink ignores input pins and never alters the stored level bit.
// - resume blink/invert reset on resume reset or reset-control write; core on platform.
// - invert 0 flags event on high input, 1 on low input; no effect on outputs.
// - upper function select reads 0 for absent pins, 1 for unmuxed, resets 03000000.
module general_purpose_io_bank #(
  parameter int BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic platform_bus_reset_n,
  input wire logic reset_ctl_write,
  input gpio_bank_pkg::reg_req_t bus_req,
  output logic [31:0] rdata,
  input wire logic [31:0] pin_in,
  output gpio_bank_pkg::pin_bus_t pin_drive,
  input gpio_bank_pkg::pin_bus_t native_drive,
  output logic [31:0] native_in,
  output logic [31:0] upper_function_gpio,
  output logic irq
);
  import gpio_bank_pkg::*;

  // synchronised pins and platform reset
  logic [32:0] sync_bus;
  logic [31:0] pin_sync_lvl;
  logic plat_rst_n_s;

  pin_sync #(
    .W(33)
  ) u_pin_sync (
    .clock(clock),
    .resetn(resetn),
    .async_in({platform_bus_reset_n, pin_in}),
    .sync_out(sync_bus)
  );

  assign pin_sync_lvl = sync_bus[31:0];
  assign plat_rst_n_s = sync_bus[32];
  assign native_in = pin_sync_lvl;

  // the platform reset is held as a level; its falling edge after power-up
  // counts once the synchroniser has settled high
  logic plat_seen_r;
  logic plat_rst;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      plat_seen_r <= 1'b0;
    end else if (plat_rst_n_s) begin
      plat_seen_r <= 1'b1;
    end
  end

  assign plat_rst = plat_seen_r & ~plat_rst_n_s;

  // registers
  logic [31:0] func_lower_r;
  logic [31:0] func_lower_nxt;
  logic [31:0] func_upper_r;
  logic [31:0] func_upper_nxt;
  logic [31:0] dir_r;
  logic [31:0] dir_nxt;
  logic [31:0] level_r;
  logic [31:0] level_nxt;
  logic [31:0] blink_r;
  logic [31:0] blink_nxt;
  logic [31:0] invert_r;
  logic [31:0] invert_nxt;
  logic [31:0] evt_status_r;
  logic [31:0] evt_status_nxt;
  logic [31:0] evt_mask_r;
  logic [31:0] evt_mask_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  pin_bus_t pin_drive_r;
  pin_bus_t pin_drive_nxt;

  // address decode
  wire wr_func_lower = bus_req.wr && bus_req.addr == `OFF_FUNC_LOWER;
  wire wr_func_upper = bus_req.wr && bus_req.addr == `OFF_FUNC_UPPER;
  wire wr_dir = bus_req.wr && bus_req.addr == `OFF_DIR;
  wire wr_level = bus_req.wr && bus_req.addr == `OFF_LEVEL;
  wire wr_blink = bus_req.wr && bus_req.addr == `OFF_BLINK;
  wire wr_invert = bus_req.wr && bus_req.addr == `OFF_INVERT;
  wire wr_status = bus_req.wr && bus_req.addr == `OFF_EVT_STATUS;
  wire wr_mask = bus_req.wr && bus_req.addr == `OFF_EVT_MASK;

  // visible values with fixed bits folded in
  wire [31:0] func_lower_rd = (func_lower_r & (`FUNC_LOWER_CORE | `FUNC_LOWER_RES))
                            | `FUNC_LOWER_ONE;
  wire [31:0] func_upper_rd = (func_upper_r & `FUNC_UPPER_CORE)
                            | `FUNC_UPPER_ONE;
  wire [31:0] dir_rd = (dir_r & `DIR_RW) | `DIR_ONE;
  wire [31:0] level_mask = `LVL_RES | `LVL_CORE;
  wire [31:0] blink_mask = `BLINK_RES | `BLINK_CORE;
  wire [31:0] invert_mask = `INV_RES | `INV_CORE;

  // pins driven by the bank: implemented and direction 0
  wire [31:0] is_output = ~dir_rd & level_mask;
  wire [31:0] is_input = dir_rd;

  // write data helper: only writable bits change
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
                                        input logic [31:0] rw);
    merge = (cur & ~rw) | (wd & rw);
  endfunction

  // lower function select
  always_comb begin
    func_lower_nxt = func_lower_r;
    if (wr_func_lower) begin
      func_lower_nxt = merge(func_lower_r, bus_req.wdata,
                             `FUNC_LOWER_CORE | `FUNC_LOWER_RES);
    end
    if (plat_rst) begin
      func_lower_nxt = func_lower_nxt | `FUNC_LOWER_CORE;
    end
  end

  // upper function select
  always_comb begin
    func_upper_nxt = func_upper_r;
    if (wr_func_upper) begin
      func_upper_nxt = merge(func_upper_r, bus_req.wdata, `FUNC_UPPER_CORE);
    end
    if (plat_rst) begin
      func_upper_nxt = func_upper_nxt | `FUNC_UPPER_CORE;
    end
  end

  // direction: writable bits all sit in the resume well
  always_comb begin
    dir_nxt = dir_r;
    if (wr_dir) begin
      dir_nxt = merge(dir_r, bus_req.wdata, `DIR_RW);
    end
  end

  // level: the stored bit is what software wrote, never touched by blink
  always_comb begin
    level_nxt = level_r;
    if (wr_level) begin
      level_nxt = merge(level_r, bus_req.wdata, level_mask);
    end
    if (reset_ctl_write) begin
      level_nxt = merge(level_nxt, `LVL_RST, `LVL_RES);
    end
    if (plat_rst) begin
      level_nxt = merge(level_nxt, `LVL_RST, `LVL_CORE);
    end
  end

  // blink enable
  always_comb begin
    blink_nxt = blink_r;
    if (wr_blink) begin
      blink_nxt = merge(blink_r, bus_req.wdata, blink_mask);
    end
    if (reset_ctl_write) begin
      blink_nxt = merge(blink_nxt, `BLINK_RST, `BLINK_RES);
    end
    if (plat_rst) begin
      blink_nxt = merge(blink_nxt, `BLINK_RST, `BLINK_CORE);
    end
  end

  // polarity invert
  always_comb begin
    invert_nxt = invert_r;
    if (wr_invert) begin
      invert_nxt = merge(invert_r, bus_req.wdata, invert_mask);
    end
    if (reset_ctl_write) begin
      invert_nxt = merge(invert_nxt, `INV_RST, `INV_RES);
    end
    if (plat_rst) begin
      invert_nxt = merge(invert_nxt, `INV_RST, `INV_CORE);
    end
  end

  // input events: active level after optional inversion, only on GPIO inputs
  wire [31:0] evt_active = (pin_sync_lvl ^ invert_r) & is_input & func_lower_rd
                         & `EVT_PINS;

  always_comb begin
    evt_status_nxt = evt_status_r;
    if (wr_status) begin
      evt_status_nxt = evt_status_r & ~bus_req.wdata;
    end
    // a new event in the clearing cycle survives the clear
    evt_status_nxt = evt_status_nxt | evt_active;
  end

  always_comb begin
    evt_mask_nxt = evt_mask_r;
    if (wr_mask) begin
      evt_mask_nxt = merge(evt_mask_r, bus_req.wdata, `EVT_PINS);
    end
  end

  // blink timebase: one toggle of the phase every half second
  logic [31:0] blink_cnt_r;
  logic [31:0] blink_cnt_nxt;
  logic blink_phase_r;
  logic blink_phase_nxt;
  wire blink_tick = blink_cnt_r == 32'(BLINK_HALF_CYCLES - 1);

  always_comb begin
    blink_cnt_nxt = blink_tick ? 32'h0000_0000 : blink_cnt_r + 32'h0000_0001;
    blink_phase_nxt = blink_tick ? ~blink_phase_r : blink_phase_r;
  end

  // pin drive: registered so the switch from native to GPIO cannot glitch
  wire [31:0] blink_flip = blink_r & is_output & {32{blink_phase_r}};
  wire [31:0] gpio_level = level_r ^ blink_flip;
  wire [31:0] use_gpio = func_lower_rd;

  // one mux per pin picks the gpio or the native path; both inputs are
  // steady before the flop takes them, so the hand-over cannot glitch
  wire [31:0] drv_level_nxt;
  wire [31:0] drv_enable_nxt;
  genvar pin_idx;
  generate
    for (pin_idx = 0; pin_idx < 32; pin_idx = pin_idx + 1) begin : g_pin_mux
      wire sel_gpio = use_gpio[pin_idx];
      assign drv_level_nxt[pin_idx] = sel_gpio ? gpio_level[pin_idx]
                                               : native_drive.level[pin_idx];
      assign drv_enable_nxt[pin_idx] = sel_gpio ? is_output[pin_idx]
                                                : native_drive.enable[pin_idx];
    end
  endgenerate

  always_comb begin
    pin_drive_nxt.level = drv_level_nxt;
    pin_drive_nxt.enable = drv_enable_nxt;
  end

  // read path: level reads the pin for inputs, the stored bit for outputs
  wire [31:0] level_rd = ((level_r & is_output) | (pin_sync_lvl & is_input))
                       & level_mask;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `OFF_FUNC_LOWER: rdata_nxt = func_lower_rd;
        `OFF_FUNC_UPPER: rdata_nxt = func_upper_rd;
        `OFF_DIR: rdata_nxt = dir_rd;
        `OFF_LEVEL: rdata_nxt = level_rd;
        `OFF_BLINK: rdata_nxt = blink_r & blink_mask;
        `OFF_INVERT: rdata_nxt = invert_r & invert_mask;
        `OFF_EVT_STATUS: rdata_nxt = evt_status_r;
        `OFF_EVT_MASK: rdata_nxt = evt_mask_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // resume-well reset returns every register to its documented value
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      func_lower_r <= `FUNC_LOWER_RST;
    end else begin
      func_lower_r <= func_lower_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      func_upper_r <= `FUNC_UPPER_RST;
    end else begin
      func_upper_r <= func_upper_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dir_r <= `DIR_RST;
    end else begin
      dir_r <= dir_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      level_r <= `LVL_RST;
    end else begin
      level_r <= level_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      blink_r <= `BLINK_RST;
    end else begin
      blink_r <= blink_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      invert_r <= `INV_RST;
    end else begin
      invert_r <= invert_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      evt_status_r <= `EVT_STATUS_RST;
      evt_mask_r <= `EVT_MASK_RST;
      blink_cnt_r <= 32'h0000_0000;
      blink_phase_r <= 1'b0;
    end else begin
      evt_status_r <= evt_status_nxt;
      evt_mask_r <= evt_mask_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      blink_phase_r <= blink_phase_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_drive_r <= '0;
      rdata_r <= 32'h0000_0000;
    end else begin
      pin_drive_r <= pin_drive_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign pin_drive = pin_drive_r;
  assign rdata = rdata_r;
  assign upper_function_gpio = func_upper_rd;
  assign irq = |(evt_status_r & evt_mask_r);

endmodule

//--- core/gpio_bank_consts.svh
`ifndef GPIO_BANK_CONSTS_SVH
`define GPIO_BANK_CONSTS_SVH

// register offsets inside the 64-byte window
`define OFF_FUNC_LOWER 6'h00
`define OFF_DIR 6'h04
`define OFF_LEVEL 6'h0c
`define OFF_BLINK 6'h18
`define OFF_EVT_STATUS 6'h20
`define OFF_EVT_MASK 6'h24
`define OFF_INVERT 6'h2c
`define OFF_FUNC_UPPER 6'h30

// lower function select: writable core bits, writable resume bits, fixed ones
`define FUNC_LOWER_CORE 32'h00bf00ff
`define FUNC_LOWER_RES 32'h00000800
`define FUNC_LOWER_ONE 32'h1b003100
`define FUNC_LOWER_RST 32'h1b003100

// upper function select (all writable bits in the core well)
`define FUNC_UPPER_CORE 32'h00000fff
`define FUNC_UPPER_ONE 32'h03000000
`define FUNC_UPPER_RST 32'h03000000

// direction: writable bits, fixed inputs, reset value
`define DIR_RW 32'h1b000000
`define DIR_ONE 32'h0000ffff
`define DIR_RST 32'h0000ffff

// level
`define LVL_RES 32'h1b000000
`define LVL_CORE 32'h00bf0000
`define LVL_RST 32'h1b3f0000

// blink
`define BLINK_RES 32'h1a000000
`define BLINK_CORE 32'h000c0000
`define BLINK_RST 32'h00000000

// polarity invert
`define INV_RES 32'h00003900
`define INV_CORE 32'h000000ff
`define INV_RST 32'h00000000

// pins that can raise an input event
`define EVT_PINS 32'h000039ff
`define EVT_STATUS_RST 32'h00000000
`define EVT_MASK_RST 32'h00000000

// blink timing
`define CLK_KHZ 50000
`define BLINK_HALF_MS 500
`define BLINK_HALF_CYCLES (`BLINK_HALF_MS * `CLK_KHZ)

`endif

//--- core/gpio_bank_pkg.sv
package gpio_bank_pkg;

  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [31:0] level;
    logic [31:0] enable;
  } pin_bus_t;

endpackage

//--- core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 33
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic out_r;
      // a change is taken only once the second and third stages agree
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          out_r <= 1'b0;
        end else begin
          s1_r <= async_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            out_r <= s3_r;
          end
        end
      end
      assign sync_out[i] = out_r;
    end
  endgenerate

endmodule

//--- bench/gpio_board.sv
`timescale 1ns/1ps
module gpio_board (
  input gpio_bank_pkg::pin_bus_t pin_drive,
  input wire logic [31:0] ext_level,
  output logic [31:0] pin_in
);
  import gpio_bank_pkg::*;
  // a driven pin shows the bank's level, an undriven one the board source
  assign pin_in = (pin_drive.enable & pin_drive.level) | (~pin_drive.enable & ext_level);
endmodule

//--- bench/general_purpose_io_bank_asserts.sv
`timescale 1ns/1ps
module general_purpose_io_bank_asserts #(
  parameter int BLINK_HALF_CYCLES = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input gpio_bank_pkg::reg_req_t bus_req,
  input wire logic [31:0] rdata,
  input gpio_bank_pkg::pin_bus_t pin_drive,
  input wire logic [31:0] upper_function_gpio,
  input wire logic irq
);
  import gpio_bank_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_upper_fixed: assert property ((upper_function_gpio & 32'hfffff000) == 32'h03000000)
    else $error("upper function fixed bits wrong");
  a_func_fixed: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 6'h00
    |-> (rdata & 32'hff40f700) == 32'h1b003100) else $error("lower function fixed bits wrong");
  a_dir_fixed: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 6'h04
    |-> (rdata & 32'he4ffffff) == 32'h0000ffff) else $error("direction fixed bits wrong");
  a_upper_read: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 6'h30
    |-> (rdata & 32'hfffff000) == 32'h03000000) else $error("upper function read wrong");
  a_level_resv: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 6'h0c
    |-> (rdata & 32'he440ffff) == 32'h0) else $error("level reserved bits set");
  a_blink_resv: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 6'h18
    |-> (rdata & 32'he5f3ffff) == 32'h0) else $error("blink reserved bits set");
  a_inv_resv: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 6'h2c
    |-> (rdata & 32'hffffc600) == 32'h0) else $error("invert reserved bits set");
  a_unmapped_zero: assert property ($past(bus_req.rd) && !($past(bus_req.addr) inside
    {6'h00, 6'h04, 6'h0c, 6'h18, 6'h20, 6'h24, 6'h2c, 6'h30}) |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  a_fixed_in_undriven: assert property ((pin_drive.enable & 32'h00003100) == 32'h0)
    else $error("fixed input pin driven");
  a_irq_masked: assert property (bus_req.wr && bus_req.addr == 6'h24 && bus_req.wdata == 32'h0
    |=> !irq) else $error("irq high with all masked");
endmodule
bind general_purpose_io_bank general_purpose_io_bank_asserts #(
  .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) u_general_purpose_io_bank_asserts (.clock(clock), .resetn(resetn), .bus_req(bus_req),
  .rdata(rdata), .pin_drive(pin_drive), .upper_function_gpio(upper_function_gpio), .irq(irq));

//--- bench/general_purpose_io_bank_tb_top.sv
`timescale 1ns/1ps
module general_purpose_io_bank_tb_top;
  import gpio_bank_pkg::*;
  localparam logic [31:0] full = 32'hffffffff;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic platform_bus_reset_n = 1'b1;
  logic reset_ctl_write = 1'b0;
  reg_req_t bus_req = '0;
  pin_bus_t native_drive = '0;
  pin_bus_t pin_drive;
  logic [31:0] rdata, pin_in, native_in, upper_function_gpio;
  logic [31:0] ext_level = 32'h0;
  logic irq, p;
  int miscompares = 0;
  int n_checks = 0;
  int n;
  always #10 clock = ~clock;
  general_purpose_io_bank #(.BLINK_HALF_CYCLES(8)) u_general_purpose_io_bank (.clock(clock),
    .resetn(resetn), .platform_bus_reset_n(platform_bus_reset_n),
    .reset_ctl_write(reset_ctl_write), .bus_req(bus_req), .rdata(rdata), .pin_in(pin_in),
    .pin_drive(pin_drive), .native_drive(native_drive), .native_in(native_in),
    .upper_function_gpio(upper_function_gpio), .irq(irq));
  gpio_board u_gpio_board (.pin_drive(pin_drive), .ext_level(ext_level), .pin_in(pin_in));
  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, rdata & m);
  endtask
  task automatic pin(input logic [31:0] m, input logic [31:0] e, input logic [31:0] g);
    chk("pin", e, g & m);
  endtask
  task automatic hard_reset;
    resetn <= 1'b0;
    idle(3);
    resetn <= 1'b1;
  endtask
  initial begin
    #(20 * 20000);
    miscompares++;
    report_and_stop;
  end
  initial begin
    hard_reset;
    rd(6'h00, full, 32'h1b003100);
    rd(6'h04, full, 32'h0000ffff);
    rd(6'h0c, full, 32'h1b3f0000);
    rd(6'h18, full, 32'h0);
    rd(6'h2c, full, 32'h0);
    rd(6'h30, full, 32'h03000000);
    chk("upper", 32'h03000000, upper_function_gpio);
    wr(6'h00, full);
    rd(6'h00, full, 32'h1bbf39ff);
    wr(6'h30, full);
    rd(6'h30, full, 32'h03000fff);
    wr(6'h08, full);
    rd(6'h08, full, 32'h0);
    wr(6'h04, 32'h0);
    rd(6'h04, full, 32'h0000ffff);
    wr(6'h04, full);
    rd(6'h04, full, 32'h1b00ffff);
    native_drive <= '{level: full, enable: full};
    wr(6'h00, 32'h0);
    idle(3);
    pin(32'h00010000, 32'h00010000, pin_drive.level & pin_drive.enable);
    wr(6'h00, 32'h00010000);
    for (int i = 0; i < 4; i++) begin
      idle(1);
      pin(32'h00010000, 32'h00010000, pin_drive.level & pin_drive.enable);
    end
    native_drive.level <= 32'h0;
    idle(3);
    pin(32'h00010000, 32'h00010000, pin_drive.level);
    wr(6'h0c, 32'h1b3e0000);
    idle(2);
    pin(32'h00010000, 32'h0, pin_drive.level);
    ext_level <= 32'h0;
    idle(6);
    rd(6'h0c, 32'h01000000, 32'h0);
    ext_level <= full;
    idle(6);
    chk("native_in", 32'h01000000, native_in & 32'h01000000);
    rd(6'h0c, 32'h01000000, 32'h01000000);
    pin(32'h01000000, 32'h0, pin_drive.enable);
    wr(6'h04, 32'h0000ffff);
    wr(6'h18, full);
    rd(6'h18, full, 32'h1a0c0000);
    for (int i = 0; i < 2; i++) begin
      p = pin_drive.level[25];
      n = 0;
      while (pin_drive.level[25] === p && n < 40) begin
        idle(1);
        n++;
      end
    end
    chk("blink half", 32'd8, 32'(n));
    rd(6'h0c, 32'h02000000, 32'h02000000);
    wr(6'h04, 32'h0200ffff);
    for (int i = 0; i < 2; i++) begin
      idle(8);
      pin(32'h02000000, 32'h0, pin_drive.enable);
      pin(32'h02000000, 32'h02000000, pin_drive.level);
    end
    wr(6'h24, 32'h00000100);
    idle(6);
    rd(6'h20, 32'h00000100, 32'h00000100);
    chk("irq", 32'h1, {31'h0, irq});
    wr(6'h2c, 32'h00000101);
    wr(6'h20, 32'h00000100);
    idle(3);
    rd(6'h20, 32'h00000100, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    ext_level <= 32'h0;
    idle(6);
    rd(6'h20, 32'h00000100, 32'h00000100);
    chk("irq", 32'h1, {31'h0, irq});
    wr(6'h24, 32'h0);
    #1 chk("irq", 32'h0, {31'h0, irq});
    wr(6'h04, 32'h0000ffff);
    wr(6'h0c, 32'h0);
    @(posedge clock);
    reset_ctl_write <= 1'b1;
    @(posedge clock);
    reset_ctl_write <= 1'b0;
    idle(2);
    rd(6'h0c, full, 32'h1b000000);
    rd(6'h18, full, 32'h000c0000);
    rd(6'h2c, full, 32'h00000001);
    wr(6'h00, 32'h00000800);
    wr(6'h0c, 32'h0);
    platform_bus_reset_n <= 1'b0;
    idle(10);
    platform_bus_reset_n <= 1'b1;
    idle(6);
    rd(6'h00, full, 32'h1bbf39ff);
    rd(6'h30, full, 32'h03000fff);
    rd(6'h0c, full, 32'h003f0000);
    rd(6'h18, full, 32'h0);
    rd(6'h2c, full, 32'h0);
    hard_reset;
    rd(6'h00, full, 32'h1b003100);
    report_and_stop;
  end
endmodule
